// ---- hw/shp_pkg.sv ----
package shp_pkg;
  // oscillator frequency strap codes
  localparam logic [2:0] XO_10M000 = 3'h0;
  localparam logic [2:0] XO_12M800 = 3'h1;
  localparam logic [2:0] XO_13M000 = 3'h2;
  localparam logic [2:0] XO_19M440 = 3'h3;
  localparam logic [2:0] XO_20M000 = 3'h4;
  localparam logic [2:0] XO_24M576 = 3'h5;
  localparam logic [2:0] XO_25M000 = 3'h6;
  localparam logic [2:0] XO_30M720 = 3'h7;
  // host interface select codes
  localparam logic [1:0] HIF_I2C_SLAVE  = 2'h0;
  localparam logic [1:0] HIF_SPI        = 2'h1;
  localparam logic [1:0] HIF_UART       = 2'h2;
  localparam logic [1:0] HIF_I2C_MASTER = 2'h3;
  // sync input / output kinds
  localparam logic [1:0] SYNC_2K  = 2'h0;
  localparam logic [1:0] SYNC_4K  = 2'h1;
  localparam logic [1:0] SYNC_8K  = 2'h2;
  localparam logic [1:0] SYNC_PPS = 2'h3;
  // output format default
  localparam logic [1:0] FMT_LVDS = 2'h0;
  localparam int NUM_REF  = 6;
  localparam int NUM_DIFF = 4;
  // timing
  localparam int CLK_PERIOD_PS   = 25000;
  localparam int RESET_MIN_US    = 50;
  localparam int STRAP_HOLD_MS   = 2;
  localparam int RESET_MIN_CYC   = (RESET_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // straps sampled early in the hold window, leaving wide margin to its end
  localparam int STRAP_SAMPLE_US = 100;
  localparam int STRAP_SAMPLE_CYC = (STRAP_SAMPLE_US * 1000000) / CLK_PERIOD_PS;
  localparam int EEPROM_DIV      = 100;
  // host shift clock half period: covers the 2-flop sync plus the registered output
  localparam int SPI_HALF_CYC    = 6;
endpackage

// ---- hw/shp_if.sv ----
`timescale 1ns/10ps
interface shp_if;
  // board-level straps / shared pins
  logic [2:0] osc_freq_strap;
  logic       frame_std_strap;
  logic       redundancy_role_pin;
  logic [2:0] i2c_addr_pins;
  logic [1:0] host_if_strap;
  logic       reset_n_pin;
  // serial port
  logic       chip_select_n;
  logic       shift_clk;
  logic       shift_edge_select;
  logic       serial_data_in;
  logic       serial_data_out;
  logic       serial_data_oe;
  logic       host_sda_o;
  logic       host_sda_oe;
  // eeprom master pins
  logic       eeprom_clock_out;
  logic       eeprom_data_o;
  logic       eeprom_data_oe;
  logic       eeprom_sda_o;
  logic       eeprom_sda_oe;
  // status pins
  logic       pll_a_lock_out;
  logic       pll_b_lock_out;
  logic       irq_o;
  logic       irq_oe;
  logic       frame_sync_out;
  logic       multiframe_sync_out;
  // test port
  logic       tck;
  logic       tms;
  logic       tdi;
  logic       trst_n;
  logic       tdo_o;
  logic       tdo_oe;
  // resolved open-drain / shared wires
  wire sdo_line    = (serial_data_oe & ~serial_data_out) | (host_sda_oe & ~host_sda_o) ? 1'b0 : 1'b1;
  wire eeprom_line = (eeprom_data_oe & ~eeprom_data_o) | (eeprom_sda_oe & ~eeprom_sda_o) ? 1'b0 : 1'b1;
  modport device (
    input  osc_freq_strap, frame_std_strap, redundancy_role_pin, i2c_addr_pins, host_if_strap,
    input  reset_n_pin, chip_select_n, shift_clk, shift_edge_select, serial_data_in,
    input  sdo_line, eeprom_line, tck, tms, tdi, trst_n,
    output serial_data_out, serial_data_oe, eeprom_clock_out, eeprom_data_o, eeprom_data_oe,
    output pll_a_lock_out, pll_b_lock_out, irq_o, irq_oe, frame_sync_out, multiframe_sync_out,
    output tdo_o, tdo_oe
  );
  modport host (
    output osc_freq_strap, frame_std_strap, redundancy_role_pin, i2c_addr_pins, host_if_strap,
    output reset_n_pin, chip_select_n, shift_clk, shift_edge_select, serial_data_in,
    output host_sda_o, host_sda_oe, eeprom_sda_o, eeprom_sda_oe, tck, tms, tdi, trst_n,
    input  sdo_line, eeprom_line, eeprom_clock_out, pll_a_lock_out, pll_b_lock_out,
    input  irq_o, irq_oe, frame_sync_out, multiframe_sync_out, tdo_o, tdo_oe
  );
endinterface

// ---- hw/shp_device.sv ----
`timescale 1ns/10ps
// Function
// RULE1: strap code picks oscillator frequency at reset
// RULE2: after reset freq straps become LOS inputs
// RULE3: frame-standard default latched from strap pin
// RULE4: after reset that pin is LOSS_OF_SIGNAL_IN_3 only
// RULE5: role from pin and control bit
// RULE6: host interface field latched from mode straps
// RULE7: eeprom master drives clock, open-drain data
// RULE8: i2c slave address low bits from pins
// RULE9: host frames each SPI access with CS low
// RULE10: device samples SERIAL_DATA_IN on shift clock rise
// RULE11: SERIAL_DATA_OUT updates on edge chosen by select
// RULE12: UART rx on SERIAL_DATA_IN pin, tx on SERIAL_DATA_OUT
// RULE13: lock outputs follow PLL lock state
// RULE14: interrupt request output is tri-stateable
// RULE15: TMS/TDI on TCK rise, TDO on fall
// RULE16: TDO high impedance except while shifting
// RULE17: low test reset resets the test port
// RULE18: idle low TCK keeps test state
// RULE19: each reference may be clock or sync input
// RULE20: sync outputs pick 8k/2k or 1PPS
// RULE21: differential outputs default to LVDS
// RULE22: reset held low at least 50 us
// RULE23: straps held 2 ms, sampled inside that window
// RULE24: host port pins routed by latched selection
module shp_device (
  // clock, reset, enable
  input  wire logic                         core_clk_i,
  input  wire logic                         resetn_i,
  input  wire logic                         clk_en_i,
  // pins
  shp_if.device                             pins,
  // core-side controls
  input  wire logic                         role_control_bit_i,
  input  wire logic                         pll_a_locked_i,
  input  wire logic                         pll_b_locked_i,
  input  wire logic                         irq_pending_i,
  input  wire logic                         irq_enable_i,
  input  wire logic [shp_pkg::NUM_REF-1:0]  ref_is_sync_i,
  input  wire logic [2*shp_pkg::NUM_REF-1:0] ref_sync_kind_i,
  input  wire logic                         fsync_pps_sel_i,
  input  wire logic                         mfsync_pps_sel_i,
  input  wire logic                         fsync_8k_i,
  input  wire logic                         mfsync_2k_i,
  input  wire logic                         pps_i,
  input  wire logic [2*shp_pkg::NUM_DIFF-1:0] out_fmt_wr_data_i,
  input  wire logic                         out_fmt_wr_i,
  input  wire logic                         tx_bit_i,
  input  wire logic [7:0]                   spi_tx_byte_i,
  input  wire logic                         eeprom_sda_i,
  // core-side status
  output logic [2:0]                        osc_freq_sel_o,
  output logic                              frame_standard_bit_o,
  output logic [1:0]                        host_if_select_field_o,
  output logic [2:0]                        i2c_addr_o,
  output logic                              master_role_o,
  output logic                              role_pin_status_o,
  output logic [3:0]                        loss_of_signal_o,
  output logic [shp_pkg::NUM_REF-1:0]       ref_sync_mask_o,
  output logic [2*shp_pkg::NUM_DIFF-1:0]    out_fmt_o,
  output logic [7:0]                        spi_rx_byte_o,
  output logic                              spi_rx_valid_o,
  output logic                              uart_rx_bit_o,
  output logic                              straps_done_o
);
  // pin synchronisers: two flops, second stage only is read
  localparam int NSYNC = 22;
  logic [NSYNC-1:0] s1, s2, pin_raw;
  assign pin_raw = {pins.osc_freq_strap, pins.frame_std_strap, pins.redundancy_role_pin,
                    pins.i2c_addr_pins, pins.host_if_strap, pins.reset_n_pin,
                    pins.chip_select_n, pins.shift_clk, pins.shift_edge_select,
                    pins.serial_data_in, pins.sdo_line, pins.eeprom_line,
                    pins.tck, pins.tms, pins.tdi, pins.trst_n, 1'b0};
  always_ff @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      s1 <= '0;
      s2 <= '0;
    end
    else if (clk_en_i)
    begin
      s1 <= pin_raw;
      s2 <= s1;
    end
  wire [2:0] osc_s   = s2[21:19];
  wire       fstd_s  = s2[18];
  wire       role_s  = s2[17];
  wire [2:0] addr_s  = s2[16:14];
  wire [1:0] mode_s  = s2[13:12];
  wire       cs_n_s  = s2[10];
  wire       sck_s   = s2[9];
  wire       edge_s  = s2[8];
  wire       sdi_s   = s2[7];
  wire       tck_s   = s2[4];
  wire       tms_s   = s2[3];
  wire       tdi_s   = s2[2];
  wire       trstn_s = s2[1];
  wire       rstpin_s = s2[11];

  // strap window: sample once partway into the hold interval after release
  logic [15:0] strap_cnt;
  logic        latched;
  wire         sample_now = !latched && (strap_cnt == 16'(shp_pkg::STRAP_SAMPLE_CYC)); // [RULE23]
  always_ff @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      strap_cnt <= '0;
      latched   <= 1'b0;
    end
    else if (clk_en_i && !rstpin_s)
    begin
      // the reset pin restarts the strap window, so straps follow every pin reset
      strap_cnt <= '0;
      latched   <= 1'b0;
    end
    else if (clk_en_i && !latched)
    begin
      strap_cnt <= strap_cnt + 16'h1;
      latched   <= sample_now;
    end

  logic [1:0] hsel;
  always_ff @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      osc_freq_sel_o         <= shp_pkg::XO_10M000;
      frame_standard_bit_o   <= 1'b0;
      hsel                   <= shp_pkg::HIF_I2C_SLAVE;
      i2c_addr_o             <= 3'h0;
    end
    else if (clk_en_i && sample_now)
    begin
      osc_freq_sel_o       <= osc_s;   // [RULE1]
      frame_standard_bit_o <= fstd_s;  // [RULE3]
      hsel                 <= mode_s;  // [RULE6]
      i2c_addr_o           <= addr_s;  // [RULE8]
    end
  assign host_if_select_field_o = hsel;
  assign straps_done_o = latched;

  // shared pins turn into loss-of-signal inputs only after sampling
  always_ff @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i)
      loss_of_signal_o <= 4'h0;
    else if (clk_en_i)
      loss_of_signal_o <= latched ? {fstd_s, osc_s} : 4'h0; // [RULE2] [RULE4]

  // role: pin reflected in status, control bit forces slave when low
  always_ff @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      role_pin_status_o <= 1'b1;
      master_role_o     <= 1'b1;
    end
    else if (clk_en_i)
    begin
      role_pin_status_o <= role_s;                       // [RULE5]
      master_role_o     <= role_s & role_control_bit_i;  // [RULE5]
    end

  // host port routing
  wire sel_spi  = latched && hsel == shp_pkg::HIF_SPI;        // [RULE24]
  wire sel_uart = latched && hsel == shp_pkg::HIF_UART;       // [RULE24]
  wire sel_i2cm = latched && hsel == shp_pkg::HIF_I2C_MASTER; // [RULE24]

  // spi shifter on synchronised clock edges
  logic sck_d;
  logic [2:0] bit_cnt;
  logic [7:0] rx_sh, tx_sh;
  wire sck_rise = sck_s & ~sck_d;
  wire sck_fall = ~sck_s & sck_d;
  wire out_edge = edge_s ? sck_fall : sck_rise; // [RULE11]
  wire spi_act  = sel_spi && !cs_n_s;           // [RULE9]
  always_ff @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      sck_d <= 1'b0;
      bit_cnt <= 3'h0;
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
      spi_rx_byte_o <= 8'h00;
      spi_rx_valid_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      sck_d <= sck_s;
      spi_rx_valid_o <= 1'b0;
      if (!spi_act)
      begin
        bit_cnt <= 3'h0;
        tx_sh   <= spi_tx_byte_i;
      end
      else
      begin
        if (sck_rise)
        begin
          rx_sh   <= {rx_sh[6:0], sdi_s};       // [RULE10]
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7)
          begin
            spi_rx_byte_o  <= {rx_sh[6:0], sdi_s};
            spi_rx_valid_o <= 1'b1;
          end
        end
        if (out_edge)
          tx_sh <= {tx_sh[6:0], 1'b0};          // [RULE11]
      end
    end

  // eeprom master clock divider
  logic [7:0] div_cnt;
  always_ff @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      div_cnt <= 8'h00;
      pins.eeprom_clock_out <= 1'b1;
      pins.eeprom_data_o <= 1'b0;
      pins.eeprom_data_oe <= 1'b0;
    end
    else if (clk_en_i)
    begin
      div_cnt <= (div_cnt == 8'(shp_pkg::EEPROM_DIV - 1)) ? 8'h00 : div_cnt + 8'h1;
      if (sel_i2cm && div_cnt == 8'h00)
        pins.eeprom_clock_out <= ~pins.eeprom_clock_out;   // [RULE7]
      else if (!sel_i2cm)
        pins.eeprom_clock_out <= 1'b1;
      pins.eeprom_data_oe <= sel_i2cm & ~eeprom_sda_i;     // [RULE7]
    end

  // shared serial output: spi data or uart tx, open-drain style low drive
  always_ff @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      pins.serial_data_out <= 1'b1;
      pins.serial_data_oe  <= 1'b0;
      uart_rx_bit_o        <= 1'b1;
    end
    else if (clk_en_i)
    begin
      pins.serial_data_out <= sel_uart ? tx_bit_i : tx_sh[7]; // [RULE12]
      pins.serial_data_oe  <= spi_act | sel_uart;             // [RULE24]
      uart_rx_bit_o        <= sel_uart ? sdi_s : 1'b1;        // [RULE12]
    end

  // status outputs
  always_ff @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      pins.pll_a_lock_out <= 1'b0;
      pins.pll_b_lock_out <= 1'b0;
      pins.irq_o <= 1'b0;
      pins.irq_oe <= 1'b0;
      pins.frame_sync_out <= 1'b0;
      pins.multiframe_sync_out <= 1'b0;
      ref_sync_mask_o <= '0;
      out_fmt_o <= {shp_pkg::NUM_DIFF{shp_pkg::FMT_LVDS}};
    end
    else if (clk_en_i)
    begin
      pins.pll_a_lock_out <= pll_a_locked_i;                           // [RULE13]
      pins.pll_b_lock_out <= pll_b_locked_i;                           // [RULE13]
      pins.irq_o  <= irq_pending_i;                                    // [RULE14]
      pins.irq_oe <= irq_enable_i;                                     // [RULE14]
      pins.frame_sync_out <= fsync_pps_sel_i ? pps_i : fsync_8k_i;     // [RULE20]
      pins.multiframe_sync_out <= mfsync_pps_sel_i ? pps_i : mfsync_2k_i; // [RULE20]
      ref_sync_mask_o <= ref_is_sync_i;                                // [RULE19]
      if (out_fmt_wr_i)
        out_fmt_o <= out_fmt_wr_data_i;                                // [RULE21]
    end

  // test port: outside test reset, a bypass-style data register takes TDI on each TCK rise and TDO enable copies tap_shift on each TCK fall
  logic tck_d, tap_shift, tap_data;
  logic [3:0] tms_hist;
  wire tck_rise = tck_s & ~tck_d;
  wire tck_fall = ~tck_s & tck_d;
  always_ff @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      tck_d <= 1'b0;
      tap_shift <= 1'b0;
      tap_data <= 1'b0;
      tms_hist <= 4'hF;
      pins.tdo_o <= 1'b0;
      pins.tdo_oe <= 1'b0;
    end
    else if (clk_en_i)
    begin
      tck_d <= tck_s;
      if (!trstn_s)
      begin
        tap_shift <= 1'b0;                         // [RULE17]
        tms_hist  <= 4'hF;
        pins.tdo_oe <= 1'b0;
      end
      else if (tck_rise)
      begin
        tms_hist  <= {tms_hist[2:0], tms_s};       // [RULE15]
        tap_data  <= tdi_s;                        // [RULE15]
        tap_shift <= (tms_hist[1:0] == 2'b10) && !tms_s;
      end
      else if (tck_fall)
      begin
        pins.tdo_o  <= tap_data;                   // [RULE15]
        pins.tdo_oe <= tap_shift;                  // [RULE16]
      end
      // outside test reset, no tck edge means every test flop simply holds [RULE18]
    end
endmodule

// ---- hw/shp_host.sv ----
`timescale 1ns/10ps
module shp_host (
  // clock, reset, enable
  input  wire logic       core_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       clk_en_i,
  // pins
  shp_if.host             pins,
  // user side straps
  input  wire logic [2:0] osc_code_i,
  input  wire logic       frame_std_i,
  input  wire logic       role_i,
  input  wire logic [2:0] i2c_addr_i,
  input  wire logic [1:0] host_mode_i,
  // user side spi
  input  wire logic       spi_start_i,
  input  wire logic [7:0] spi_byte_i,
  input  wire logic       spi_edge_sel_i,
  output logic [7:0]      spi_rd_byte_o,
  output logic            spi_busy_o,
  output logic            in_reset_o
);
  // reset pulse then straps held past the device sample point [RULE22] [RULE23]
  localparam int HOLD_CYC = shp_pkg::STRAP_HOLD_MS * 40000;
  logic [16:0] rcnt;
  wire rel = rcnt >= 17'(shp_pkg::RESET_MIN_CYC);
  always_ff @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i)
      rcnt <= '0;
    else if (clk_en_i && rcnt != 17'(shp_pkg::RESET_MIN_CYC + HOLD_CYC))
      rcnt <= rcnt + 17'h1;
  wire hold = rcnt < 17'(shp_pkg::RESET_MIN_CYC + HOLD_CYC);
  logic ssck, sd;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic [3:0] ph;
  wire ph_end = ph == 4'(shp_pkg::SPI_HALF_CYC - 1);
  always_ff @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      in_reset_o <= 1'b1;
      ssck <= 1'b0;
      cnt <= 4'h0;
      sh <= 8'h00;
      ph <= 4'h0;
      spi_busy_o <= 1'b0;
      spi_rd_byte_o <= 8'h00;
      sd <= 1'b0;
    end
    else if (clk_en_i)
    begin
      in_reset_o <= !rel;
      if (!spi_busy_o && spi_start_i && !hold)
      begin
        spi_busy_o <= 1'b1;  // [RULE9]
        sh <= spi_byte_i;
        sd <= spi_byte_i[7]; // [RULE10]
        cnt <= 4'h0;
        ph <= 4'h0;
        ssck <= 1'b0;
      end
      else if (spi_busy_o)
      begin
        // slow phases: data settles a half period ahead of each rise
        ph <= ph_end ? 4'h0 : ph + 4'h1;
        if (ph_end)
        begin
          ssck <= ~ssck;
          if (!ssck)
            sh <= {sh[6:0], pins.sdo_line};
          else
          begin
            sd  <= sh[7];    // [RULE10]
            cnt <= cnt + 4'h1;
            if (cnt == 4'h7)
            begin
              spi_busy_o <= 1'b0;
              spi_rd_byte_o <= sh;
            end
          end
        end
      end
    end
  always_comb
  begin
    pins.reset_n_pin        = rel;
    pins.osc_freq_strap     = osc_code_i;
    pins.frame_std_strap    = frame_std_i;
    pins.redundancy_role_pin = role_i;
    pins.host_if_strap      = host_mode_i;
    pins.i2c_addr_pins      = i2c_addr_i;                        // [RULE8]
    pins.chip_select_n      = hold ? i2c_addr_i[0] : !spi_busy_o; // [RULE9]
    pins.shift_clk          = ssck;
    pins.shift_edge_select  = hold ? i2c_addr_i[1] : spi_edge_sel_i;
    pins.serial_data_in     = hold ? i2c_addr_i[2] : sd;
    pins.host_sda_o         = 1'b1;
    pins.host_sda_oe        = 1'b0;
    pins.eeprom_sda_o       = 1'b1;
    pins.eeprom_sda_oe      = 1'b0;
    pins.tck                = 1'b0;
    pins.tms                = 1'b1;
    pins.tdi                = 1'b1;
    pins.trst_n             = 1'b0;                              // [RULE17]
  end
endmodule

// ---- verification/shp_asserts.sv ----
`timescale 1ns/10ps
module shp_asserts (
  // clock, reset
  input wire logic       core_clk_i,
  input wire logic       resetn_i,
  // core side
  input wire logic       pll_a_locked_i,
  input wire logic       pll_b_locked_i,
  input wire logic       irq_enable_i,
  input wire logic       fsync_pps_sel_i,
  input wire logic       pps_i,
  input wire logic [1:0] host_if_select_field_o,
  // link
  input wire logic       pll_a_lock_out,
  input wire logic       pll_b_lock_out,
  input wire logic       irq_oe,
  input wire logic       frame_sync_out,
  input wire logic       trst_n,
  input wire logic       tdo_oe,
  input wire logic       chip_select_n,
  input wire logic       serial_data_oe,
  input wire logic       eeprom_clock_out,
  input wire logic       eeprom_data_o,
  input wire logic       eeprom_data_oe
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // test reset passes two sync flops before the port sees it
  sequence trst_held;
    !trst_n [*4];
  endsequence
  sequence cs_ends;
    $rose(chip_select_n) && host_if_select_field_o == shp_pkg::HIF_SPI;
  endsequence

  AST_LOCK_A_RISE: assert property ($rose(pll_a_locked_i) |=> pll_a_lock_out)
    else $error("pll a lock output missed the lock");
  AST_LOCK_B_FALL: assert property ($fell(pll_b_locked_i) |=> !pll_b_lock_out)
    else $error("pll b lock output stayed high");
  AST_IRQ_RELEASE: assert property ($fell(irq_enable_i) |-> ##[1:2] !irq_oe)
    else $error("interrupt output not released");
  AST_TDO_RESET: assert property (trst_held |-> !tdo_oe)
    else $error("test data output driven in test reset");
  AST_EEPROM_OD: assert property (eeprom_data_oe |-> !eeprom_data_o)
    else $error("eeprom data driven high");
  AST_SDO_RELEASE: assert property (cs_ends |-> ##[1:4] !serial_data_oe)
    else $error("serial data out still driven after select");
  AST_EEPROM_IDLE: assert property (host_if_select_field_o != shp_pkg::HIF_I2C_MASTER
    |-> !eeprom_data_oe && eeprom_clock_out)
    else $error("eeprom pins active outside master mode");
  AST_FSYNC_PPS: assert property ($past(resetn_i) && $past(fsync_pps_sel_i)
    |-> frame_sync_out == $past(pps_i))
    else $error("frame sync output not the pulse");
endmodule

// ---- verification/test_strap_and_host_port_pins.sv ----
`timescale 1ns/10ps
module test_strap_and_host_port_pins;
  logic        core_clk_i;
  logic        resetn_i;
  logic [31:0] seed;
  logic [31:0] stim;
  logic [2:0]  osc_code;
  logic        frame_std;
  logic        role;
  logic [2:0]  i2c_addr;
  logic [1:0]  host_mode;
  logic        role_ctrl;
  logic        spi_start;
  logic [7:0]  spi_byte;
  logic        edge_sel;
  logic [7:0]  fmt_data;
  logic        fmt_wr;
  logic [2:0]  osc_sel;
  logic        fstd_bit;
  logic [1:0]  hif;
  logic [2:0]  addr_o;
  logic        master;
  logic        role_st;
  logic [3:0]  los;
  logic [5:0]  sync_mask;
  logic [7:0]  fmt_o;
  logic [7:0]  rx_byte;
  logic        rx_valid;
  logic        done;
  logic        busy;
  logic [7:0]  rd_byte;
  logic        uart_rx;
  logic [7:0]  q_bytes[$];
  int          err_total;
  int          checked;

  shp_if link();

  shp_device shp_device_inst (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .clk_en_i(1'b1), .pins(link.device),
    .role_control_bit_i(role_ctrl), .pll_a_locked_i(stim[0]), .pll_b_locked_i(stim[1]),
    .irq_pending_i(stim[2]), .irq_enable_i(stim[3]), .ref_is_sync_i(stim[16:11]),
    .ref_sync_kind_i(stim[28:17]), .fsync_pps_sel_i(stim[4]), .mfsync_pps_sel_i(stim[5]),
    .fsync_8k_i(stim[6]), .mfsync_2k_i(stim[7]), .pps_i(stim[8]),
    .out_fmt_wr_data_i(fmt_data), .out_fmt_wr_i(fmt_wr), .tx_bit_i(stim[9]),
    .spi_tx_byte_i(stim[31:24]), .eeprom_sda_i(stim[10]), .osc_freq_sel_o(osc_sel),
    .frame_standard_bit_o(fstd_bit), .host_if_select_field_o(hif), .i2c_addr_o(addr_o),
    .master_role_o(master), .role_pin_status_o(role_st), .loss_of_signal_o(los),
    .ref_sync_mask_o(sync_mask), .out_fmt_o(fmt_o), .spi_rx_byte_o(rx_byte),
    .spi_rx_valid_o(rx_valid), .uart_rx_bit_o(uart_rx), .straps_done_o(done));

  shp_host shp_host_inst (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .clk_en_i(1'b1), .pins(link.host),
    .osc_code_i(osc_code), .frame_std_i(frame_std), .role_i(role), .i2c_addr_i(i2c_addr),
    .host_mode_i(host_mode), .spi_start_i(spi_start), .spi_byte_i(spi_byte),
    .spi_edge_sel_i(edge_sel), .spi_rd_byte_o(rd_byte), .spi_busy_o(busy), .in_reset_o());

  shp_asserts shp_asserts_inst (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .pll_a_locked_i(stim[0]),
    .pll_b_locked_i(stim[1]), .irq_enable_i(stim[3]), .fsync_pps_sel_i(stim[4]),
    .pps_i(stim[8]), .host_if_select_field_o(hif), .pll_a_lock_out(link.pll_a_lock_out),
    .pll_b_lock_out(link.pll_b_lock_out), .irq_oe(link.irq_oe),
    .frame_sync_out(link.frame_sync_out), .trst_n(link.trst_n), .tdo_oe(link.tdo_oe),
    .chip_select_n(link.chip_select_n), .serial_data_oe(link.serial_data_oe),
    .eeprom_clock_out(link.eeprom_clock_out), .eeprom_data_o(link.eeprom_data_o),
    .eeprom_data_oe(link.eeprom_data_oe));

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    xs = y ^ (y << 5);
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // the spi pass sits out the 2 ms strap hold, about 82000 cycles
  initial
  begin
    repeat (100000) @(posedge core_clk_i);
    err_total++;
    wrap_up;
  end

  // valid stands one cycle, so it is taken at the edge itself
  always @(posedge core_clk_i)
  begin
    if (resetn_i && rx_valid === 1'b1)
    begin
      if (q_bytes.size() == 0)
        chk("spi_unexpected", 8'h00, 8'h01);
      else
        chk("spi_rx_byte", q_bytes.pop_front(), rx_byte);
    end
  end

  initial
  begin
    {err_total, checked} = '0;
    {stim, fmt_data, fmt_wr, spi_start, spi_byte, edge_sel} = '0;
    {osc_code, frame_std, role, i2c_addr, host_mode} = '0;
    seed = 32'h00007E15;
    role_ctrl = 1'b1;
    resetn_i = 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      resetn_i = 1'b0;
      seed = xs(seed);
      {edge_sel, role, i2c_addr, frame_std, osc_code} = seed[8:0];
      host_mode = p == 1 ? shp_pkg::HIF_SPI : {1'b1, seed[10]};
      step(20);
      resetn_i = 1'b1;
      chk("out_fmt_reset", 8'h00, fmt_o);
      for (int i = 0; i < 41000 && done !== 1'b1; i++)
        step(1);
      chk("straps_done", 8'h01, 8'(done));
      chk("osc_sel", 8'(osc_code), 8'(osc_sel));
      chk("frame_bit", 8'(frame_std), 8'(fstd_bit));
      chk("host_if", 8'(host_mode), 8'(hif));
      chk("i2c_addr", 8'(i2c_addr), 8'(addr_o));
      chk("role_pin", 8'(role), 8'(role_st));
      // late strap moves must reach only the loss-of-signal inputs
      seed = xs(seed);
      osc_code = ~osc_code;
      frame_std = ~frame_std;
      step(8);
      chk("frame_kept", 8'(!frame_std), 8'(fstd_bit));
      chk("osc_kept", 8'(osc_code ^ 3'h7), 8'(osc_sel));
      chk("los", 8'({frame_std, osc_code}), 8'(los));
      chk("uart_rx", 8'(host_mode == shp_pkg::HIF_UART ? i2c_addr[2] : 1'b1), 8'(uart_rx));
      for (int c = 0; c < 2; c++)
      begin
        role_ctrl = c[0];
        step(6);
        chk("master", 8'(role & role_ctrl), 8'(master));
      end
      fmt_data = seed[15:8];
      fmt_wr = 1'b1;
      step(1);
      fmt_wr = 1'b0;
      step(2);
      chk("out_fmt", fmt_data, fmt_o);
      for (int b = 0; b < 3; b++)
      begin
        seed = xs(seed);
        spi_byte = seed[7:0];
        if (host_mode == shp_pkg::HIF_SPI)
          q_bytes.push_back(spi_byte);
        spi_start = 1'b1;
        // the host holds off until the strap hold ends
        for (int i = 0; i < 90000 && busy !== 1'b1 && host_mode == shp_pkg::HIF_SPI; i++)
          step(1);
        step(1);
        spi_start = 1'b0;
        for (int i = 0; i < 5000 && busy !== 1'b0; i++)
          step(1);
        chk("spi_idle", 8'h00, 8'(busy));
        if (host_mode == shp_pkg::HIF_SPI)
          chk("spi_tx_byte", stim[31:24], rd_byte);
        step(8);
      end
      chk("spi_missing", 8'h00, 8'(q_bytes.size()));
      q_bytes.delete();
      for (int i = 0; i < 400; i++)
      begin
        seed = xs(seed);
        stim = seed;
        step(1);
        chk("lock_a", 8'(stim[0]), 8'(link.pll_a_lock_out));
        chk("lock_b", 8'(stim[1]), 8'(link.pll_b_lock_out));
        chk("irq", 8'(stim[3:2]), 8'({link.irq_oe, link.irq_o}));
        chk("fsync", 8'(stim[4] ? stim[8] : stim[6]), 8'(link.frame_sync_out));
        chk("mfsync", 8'(stim[5] ? stim[8] : stim[7]), 8'(link.multiframe_sync_out));
        chk("ref_mask", 8'(stim[16:11]), 8'(sync_mask));
        if (host_mode == shp_pkg::HIF_UART)
          chk("uart_tx", 8'(stim[9]), 8'(link.sdo_line));
      end
    end
    wrap_up;
  end
endmodule
